// file: shared/sdc_map.svh
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define SDC_CLK_MHZ 125
// least times in ns, rounded up to whole cycles, never below one
`define SDC_TRCD_NS 20
`define SDC_TRP_NS 20
`define SDC_SELF_EXIT_NS 70
`define SDC_CYC_UP(ns) ((((ns) * `SDC_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
  (((ns) * `SDC_CLK_MHZ + 999) / 1000))
`define SDC_TRCD_CYC `SDC_CYC_UP(`SDC_TRCD_NS)
`define SDC_TRP_CYC `SDC_CYC_UP(`SDC_TRP_NS)
`define SDC_SELF_EXIT_CYC `SDC_CYC_UP(`SDC_SELF_EXIT_NS)

// ************************************************************
// command encodings {row strobe, column strobe, write strobe}
// ************************************************************
`define SDC_CMD_MODE 3'h0
`define SDC_CMD_REF 3'h1
`define SDC_CMD_PRE 3'h2
`define SDC_CMD_ACT 3'h3
`define SDC_CMD_WRITE 3'h4
`define SDC_CMD_READ 3'h5
`define SDC_CMD_STOP 3'h6
`define SDC_CMD_NO_OP 3'h7

// ************************************************************
// address fields and reset values
// ************************************************************
`define SDC_AP_BIT 10
`define SDC_COL_MSB 7
`define SDC_BL_MSB 2
`define SDC_MODE_RST 12'h000
`define SDC_ROW_RST 12'h000

`endif

// file: shared/sdc_pkg.sv
`default_nettype none

package sdc_pkg;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
  } sdc_bank_t;

  typedef enum logic [2:0] {
    PS_NORMAL, PS_PDOWN, PS_SELF, PS_XSR, PS_SUSP
  } sdc_pwr_t;

endpackage
`default_nettype wire

// file: logic/sdc_bank.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.svh"

module sdc_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // decoded commands for this bank
  input wire logic hold_i,
  input wire logic act_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic pre_i,
  input wire logic ap_i,
  input wire logic stop_i,
  input wire logic done_i,
  // state
  output var sdc_pkg::sdc_bank_t state_o
);
  import sdc_pkg::*;

  sdc_bank_t state_q, state_d;
  logic [3:0] timer_q, timer_d;
  wire logic timer_zero = (timer_q == 4'h0);
  wire logic access = rd_i | wr_i;
  wire sdc_bank_t access_state = rd_i ? (ap_i ? BK_READ_AP : BK_READ) :
                                        (ap_i ? BK_WRITE_AP : BK_WRITE);

  assign state_o = state_q;

  always_comb begin
    state_d = state_q;
    timer_d = timer_zero ? timer_q : timer_q - 4'h1;
    // clock suspend freezes the whole bank, timers included
    if (hold_i) begin
      timer_d = timer_q;
    end else begin
      case (state_q)
        BK_IDLE: begin
          if (act_i) begin
            state_d = BK_ACTIVATING;
            timer_d = 4'(`SDC_TRCD_CYC - 1);
          end
        end
        BK_ACTIVATING: begin
          if (timer_zero) begin
            state_d = BK_ACTIVE;
          end
        end
        BK_ACTIVE: begin
          if (pre_i) begin
            state_d = BK_PRECHARGING;
            timer_d = 4'(`SDC_TRP_CYC - 1);
          end else if (access) begin
            state_d = access_state;
          end
        end
        BK_READ, BK_WRITE: begin
          // precharge truncates, a new access restarts, stop or end returns
          if (pre_i) begin
            state_d = BK_PRECHARGING;
            timer_d = 4'(`SDC_TRP_CYC - 1);
          end else if (access) begin
            state_d = access_state;
          end else if (stop_i || done_i) begin
            state_d = BK_ACTIVE;
          end
        end
        BK_READ_AP, BK_WRITE_AP: begin
          if (pre_i || stop_i || done_i) begin
            state_d = BK_PRECHARGING;
            timer_d = 4'(`SDC_TRP_CYC - 1);
          end
        end
        BK_PRECHARGING: begin
          if (timer_zero) begin
            state_d = BK_IDLE;
          end
        end
        default: begin
          state_d = BK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= BK_IDLE;
      timer_q <= 4'h0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

endmodule
`default_nettype wire

// file: logic/sdc_top.sv
// How it works
// - mode load copies all twelve address lines into the mode register
// - activate opens the addressed row in the selected bank until precharge
// - chip select high or all strobes high does nothing new
// - strobe levels decode into activate, read, write, stop, precharge, refresh, mode
// - reads and writes take column bits 7:0, bank, and per-command auto precharge
// - precharge closes the selected bank, or all banks when the flag is high; a bank still activating ignores it
// - refresh encoding auto refreshes with clock enable high, self refreshes when low
// - refresh rows come from an internal counter; other inputs ignored
// - byte mask applies to write data at once, to read data two clocks later
// - actions depend on current and previous clock enable, command and state
// - clock enable high with no-operation leaves power-down on the next edge
// - self refresh exit waits the recovery time before reaching idle
// - clock enable high ends clock suspend; next edge takes commands
// - read burst: new access restarts, stop ends, precharge truncates
// - write burst: new access restarts, stop ends, precharge truncates
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.svh"

module sdc_top (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // command pins, driven on the same clock by the controller
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [1:0] BANK_SELECT_I,
  input wire logic [11:0] ADDRESS_LINES_I,
  input wire logic [1:0] DQM_I,
  // configuration and row tracking
  output logic [11:0] MODE_REG_O,
  output logic [11:0] ACT_ROW_O,
  output logic [1:0] ACT_BANK_O,
  // access strobes
  output logic RD_START_O,
  output logic WR_START_O,
  output logic [7:0] COL_O,
  output logic [1:0] ACC_BANK_O,
  output logic AUTO_PRE_O,
  output logic BURST_STOP_O,
  output logic [1:0] WR_MASK_O,
  output logic [1:0] RD_MASK_O,
  // refresh
  output logic REFRESH_O,
  output logic [11:0] REFRESH_ROW_O,
  // state
  output var sdc_pkg::sdc_pwr_t PWR_STATE_O,
  output logic [11:0] BANK_STATE_O
);
  import sdc_pkg::*;

  // ************************************************************
  // command decode
  // ************************************************************
  logic cke_q;
  sdc_pwr_t pwr_q, pwr_d;
  logic [3:0] xsr_q, xsr_d;
  logic bursting_q;
  logic [8:0] burst_cnt_q;
  logic [1:0] burst_bank_q;
  logic [1:0] rd_mask_p_q;
  sdc_bank_t bank_state [4];

  wire logic [2:0] strobes = {RAS_N_I, CAS_N_I, WE_N_I};
  wire logic is_idle_cmd = CS_N_I | (strobes == `SDC_CMD_NO_OP);
  wire logic sel = ~CS_N_I;
  wire logic live = (pwr_q == PS_NORMAL) & cke_q & CKE_I;
  wire logic c_mode = live & sel & (strobes == `SDC_CMD_MODE);
  wire logic c_ref = live & sel & (strobes == `SDC_CMD_REF);
  wire logic c_pre = live & sel & (strobes == `SDC_CMD_PRE);
  wire logic c_act = live & sel & (strobes == `SDC_CMD_ACT);
  wire logic c_wr = live & sel & (strobes == `SDC_CMD_WRITE);
  wire logic c_rd = live & sel & (strobes == `SDC_CMD_READ);
  wire logic c_stop = live & sel & (strobes == `SDC_CMD_STOP) & bursting_q;
  wire logic ap = ADDRESS_LINES_I[`SDC_AP_BIT];
  wire logic access = c_rd | c_wr;
  wire logic susp = (pwr_q == PS_SUSP);
  wire logic cke_drop = (pwr_q == PS_NORMAL) & cke_q & ~CKE_I;
  wire logic ref_drop = sel & (strobes == `SDC_CMD_REF);

  function automatic logic [8:0] burst_len(input logic [11:0] mode);
    case (mode[`SDC_BL_MSB:0])
      3'h0: burst_len = 9'h001;
      3'h1: burst_len = 9'h002;
      3'h2: burst_len = 9'h004;
      3'h3: burst_len = 9'h008;
      default: burst_len = 9'h100;
    endcase
  endfunction

  // ************************************************************
  // banks
  // ************************************************************
  logic all_idle;
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < 4; b++) begin
      all_idle = all_idle & (bank_state[b] == BK_IDLE);
    end
  end

  // a burst ends on its last beat, or when another access interrupts it
  wire logic burst_end = bursting_q & ~susp & ((burst_cnt_q == 9'h000) | access);

  for (genvar b = 0; b < 4; b++) begin : g_bank
    wire logic hit = (BANK_SELECT_I == 2'(b));
    wire logic mine = (burst_bank_q == 2'(b));
    sdc_bank u_bank (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .hold_i(susp),
      .act_i(c_act & hit),
      .rd_i(c_rd & hit),
      .wr_i(c_wr & hit),
      .pre_i(c_pre & (ap | hit)),
      .ap_i(ap),
      .stop_i(c_stop & mine),
      .done_i(burst_end & mine & ~(access & hit)),
      .state_o(bank_state[b])
    );
    assign BANK_STATE_O[3*b +: 3] = bank_state[b];
  end

  // ************************************************************
  // power state
  // ************************************************************
  always_comb begin
    pwr_d = pwr_q;
    xsr_d = (xsr_q == 4'h0) ? xsr_q : xsr_q - 4'h1;
    case (pwr_q)
      PS_NORMAL: begin
        if (cke_drop) begin
          if (all_idle && ref_drop) begin
            pwr_d = PS_SELF;
          end else if (all_idle && is_idle_cmd) begin
            pwr_d = PS_PDOWN;
          end else if (bursting_q) begin
            pwr_d = PS_SUSP;
          end
        end
      end
      PS_PDOWN: begin
        if (CKE_I && is_idle_cmd) begin
          pwr_d = PS_NORMAL;
        end
      end
      PS_SELF: begin
        if (CKE_I && is_idle_cmd) begin
          pwr_d = PS_XSR;
          xsr_d = 4'(`SDC_SELF_EXIT_CYC - 1);
        end
      end
      PS_XSR: begin
        if (xsr_q == 4'h0) begin
          pwr_d = PS_NORMAL;
        end
      end
      PS_SUSP: begin
        if (CKE_I) begin
          pwr_d = PS_NORMAL;
        end
      end
      default: begin
        pwr_d = PS_NORMAL;
      end
    endcase
  end

  assign PWR_STATE_O = pwr_q;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cke_q <= 1'b1;
      pwr_q <= PS_NORMAL;
      xsr_q <= 4'h0;
    end else begin
      cke_q <= CKE_I;
      pwr_q <= pwr_d;
      xsr_q <= xsr_d;
    end
  end

  // ************************************************************
  // burst tracking
  // ************************************************************
  // the counter stands still during clock suspend, so a burst resumes intact
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bursting_q <= 1'b0;
      burst_cnt_q <= 9'h000;
      burst_bank_q <= 2'h0;
    end else if (access) begin
      bursting_q <= 1'b1;
      burst_cnt_q <= burst_len(MODE_REG_O) - 9'h001;
      burst_bank_q <= BANK_SELECT_I;
    end else if (c_stop || (c_pre && (ap || BANK_SELECT_I == burst_bank_q))) begin
      bursting_q <= 1'b0;
    end else if (burst_end) begin
      bursting_q <= 1'b0;
    end else if (bursting_q && !susp) begin
      burst_cnt_q <= burst_cnt_q - 9'h001;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MODE_REG_O <= `SDC_MODE_RST;
      ACT_ROW_O <= 12'h000;
      ACT_BANK_O <= 2'h0;
    end else if (c_mode) begin
      MODE_REG_O <= ADDRESS_LINES_I;
    end else if (c_act) begin
      ACT_ROW_O <= ADDRESS_LINES_I;
      ACT_BANK_O <= BANK_SELECT_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_START_O <= 1'b0;
      WR_START_O <= 1'b0;
      COL_O <= 8'h00;
      ACC_BANK_O <= 2'h0;
      AUTO_PRE_O <= 1'b0;
      BURST_STOP_O <= 1'b0;
      WR_MASK_O <= 2'h0;
    end else begin
      RD_START_O <= c_rd;
      WR_START_O <= c_wr;
      BURST_STOP_O <= c_stop;
      if (access) begin
        COL_O <= ADDRESS_LINES_I[`SDC_COL_MSB:0];
        ACC_BANK_O <= BANK_SELECT_I;
        AUTO_PRE_O <= ap;
        WR_MASK_O <= DQM_I;
      end
    end
  end

  // read mask lags its registration by two edges
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_mask_p_q <= 2'h0;
      RD_MASK_O <= 2'h0;
    end else begin
      rd_mask_p_q <= DQM_I;
      RD_MASK_O <= rd_mask_p_q;
    end
  end

  // address lines are never looked at here: the row counter supplies the row
  wire logic ref_go = c_ref | (cke_drop & all_idle & ref_drop);
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REFRESH_O <= 1'b0;
      REFRESH_ROW_O <= `SDC_ROW_RST;
    end else begin
      REFRESH_O <= ref_go;
      if (ref_go) begin
        REFRESH_ROW_O <= REFRESH_ROW_O + 12'h001;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  mode_load_a: assert property (c_mode |=> MODE_REG_O == $past(ADDRESS_LINES_I))
    else $error("mode register not loaded from address lines");
  act_row_a: assert property (c_act |=> ACT_ROW_O == $past(ADDRESS_LINES_I)
    && ACT_BANK_O == $past(BANK_SELECT_I))
    else $error("activate row or bank not captured");
  idle_cycle_a: assert property (is_idle_cmd |=> !RD_START_O && !WR_START_O && !REFRESH_O)
    else $error("inhibit or no-operation started an action");
  read_field_a: assert property (c_rd |=> RD_START_O && !WR_START_O
    && COL_O == $past(ADDRESS_LINES_I[7:0]) && AUTO_PRE_O == $past(ap))
    else $error("read column or auto precharge wrong");
  pre_all_a: assert property (c_pre && ap |=> BANK_STATE_O[2:0] != BK_ACTIVE
    && BANK_STATE_O[5:3] != BK_ACTIVE && BANK_STATE_O[8:6] != BK_ACTIVE
    && BANK_STATE_O[11:9] != BK_ACTIVE)
    else $error("precharge all left a bank open");
  self_entry_a: assert property (cke_drop && all_idle && ref_drop
    |=> PWR_STATE_O == PS_SELF && REFRESH_O)
    else $error("self refresh not entered");
  rd_mask_a: assert property (##2 RD_MASK_O == $past(DQM_I, 2))
    else $error("read mask not two clocks late");
  wr_mask_a: assert property (c_wr |=> WR_START_O && WR_MASK_O == $past(DQM_I))
    else $error("write mask not same cycle");
  pd_exit_a: assert property (pwr_q == PS_PDOWN && CKE_I && is_idle_cmd
    |=> PWR_STATE_O == PS_NORMAL)
    else $error("power-down exit late");
  xsr_wait_a: assert property ($rose(pwr_q == PS_XSR) |->
    (pwr_q == PS_XSR)[*8] ##1 pwr_q == PS_XSR ##1 pwr_q == PS_NORMAL)
    else $error("self refresh recovery length wrong");
  susp_hold_a: assert property (susp && !CKE_I |=> susp ##0 $stable(burst_cnt_q))
    else $error("clock suspend not held");

endmodule
`default_nettype wire

// file: dv/sdc_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.svh"

module sdc_ctrl_model (
  // clock
  input wire logic clk_i,
  // command pins toward the memory
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] ba_o,
  output logic [11:0] addr_o,
  output logic [1:0] dqm_o
);
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = `SDC_CMD_NO_OP;
    ba_o = 2'h0;
    addr_o = 12'h000;
    dqm_o = 2'h0;
  end

  // ************************************************************
  // one command per call, launched at the falling edge
  // ************************************************************
  // callers drop clock enable only for clock suspend, power-down and self refresh, hold the
  // activate, precharge and refresh waits, and send only listed sequences
  task automatic issue(input logic cke, input logic cs_n, input logic [2:0] cmd,
                       input logic [1:0] ba, input logic [11:0] addr, input logic [1:0] dqm);
    @(negedge clk_i);
    cke_o <= cke;
    cs_n_o <= cs_n;
    {ras_n_o, cas_n_o, we_n_o} <= cmd;
    dqm_o <= dqm;
    // don't-care buses toggle so a stale value can never pass for a real one
    if (cs_n || cmd == `SDC_CMD_NO_OP || cmd == `SDC_CMD_REF) begin
      addr_o <= ~addr_o;
      ba_o <= ~ba_o;
    end else begin
      addr_o <= addr;
      ba_o <= ba;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/tb_sdc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.svh"

module tb_sdc_top;
  import sdc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic cke, cs_n, ras_n, cas_n, we_n;
  wire logic [1:0] ba, dqm, act_bank, acc_bank, wr_mask, rd_mask;
  wire logic [11:0] addr, mode_reg, act_row, ref_row, st;
  wire logic rd_start, wr_start, auto_pre, stop, refresh;
  wire logic [7:0] col;
  sdc_pwr_t pwr;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int cnt;
  integer seed = 32'h5AC3;
  logic [11:0] v;
  logic [11:0] r;
  logic [1:0] dq[$];

  always #4 clk = ~clk;

  sdc_ctrl_model u_sdc_ctrl_model (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm));

  sdc_top u_sdc_top (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .CS_N_I(cs_n),
    .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BANK_SELECT_I(ba),
    .ADDRESS_LINES_I(addr), .DQM_I(dqm), .MODE_REG_O(mode_reg), .ACT_ROW_O(act_row),
    .ACT_BANK_O(act_bank), .RD_START_O(rd_start), .WR_START_O(wr_start), .COL_O(col),
    .ACC_BANK_O(acc_bank), .AUTO_PRE_O(auto_pre), .BURST_STOP_O(stop),
    .WR_MASK_O(wr_mask), .RD_MASK_O(rd_mask), .REFRESH_O(refresh),
    .REFRESH_ROW_O(ref_row), .PWR_STATE_O(pwr), .BANK_STATE_O(st));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // issue, then look just after the edge that takes it
  task automatic cmd(input logic k, input logic c, input logic [2:0] op, input logic [1:0] b,
                     input logic [11:0] a, input logic [1:0] m);
    u_sdc_ctrl_model.issue(k, c, op, b, a, m);
    @(posedge clk);
    #1;
  endtask

  task automatic idle_cycles(input int n);
    repeat (n) cmd(1'b1, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
  endtask

  function automatic logic [11:0] bst(input int b);
    return {9'h000, st[3*b +: 3]};
  endfunction

  function automatic logic [11:0] ex(input logic [2:0] s);
    return {9'h000, s};
  endfunction

  // ************************************************************
  // hang guard: the whole sequence needs well under 1000 cycles
  // ************************************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    #1;
    check("pwr rst", 12'(pwr), ex(PS_NORMAL));
    check("banks rst", st, 12'h000);
    check("mode rst", mode_reg, `SDC_MODE_RST);
    // mode load, then an inhibited mode load that must not land
    for (int i = 0; i < 4; i++) begin
      v = 12'($random(seed));
      cmd(1'b1, 1'b0, `SDC_CMD_MODE, 2'h0, v, 2'h0);
      check("mode", mode_reg, v);
      cmd(1'b1, 1'b1, `SDC_CMD_MODE, 2'h0, ~v, 2'h0);
      check("mode inhibit", mode_reg, v);
    end
    // full page bursts keep reads and writes running until stopped
    cmd(1'b1, 1'b0, `SDC_CMD_MODE, 2'h0, 12'h007, 2'h0);
    for (int b = 0; b < 4; b++) begin
      v = 12'($random(seed));
      cmd(1'b1, 1'b0, `SDC_CMD_ACT, 2'(b), v, 2'h0);
      check("act row", act_row, v);
      check("act bank", {10'h000, act_bank}, 12'(b));
      check("activating", bst(b), ex(BK_ACTIVATING));
      idle_cycles(3);
      check("active", bst(b), ex(BK_ACTIVE));
      v = 12'($random(seed)) & 12'hBFF;
      cmd(1'b1, 1'b0, `SDC_CMD_READ, 2'(b), v, 2'h0);
      check("rd start", {11'h000, rd_start}, 12'h001);
      check("rd col", {4'h0, col}, {4'h0, v[7:0]});
      check("rd bank", {10'h000, acc_bank}, 12'(b));
      check("rd ap", {11'h000, auto_pre}, 12'h000);
      check("reading", bst(b), ex(BK_READ));
      r = 12'($random(seed)) & 12'h003;
      cmd(1'b1, 1'b0, `SDC_CMD_WRITE, 2'(b), v, r[1:0]);
      check("wr start", {11'h000, wr_start}, 12'h001);
      check("wr mask", {10'h000, wr_mask}, r);
      check("writing", bst(b), ex(BK_WRITE));
      cmd(1'b1, 1'b0, `SDC_CMD_STOP, 2'h0, 12'h000, 2'h0);
      check("stop", {11'h000, stop}, 12'h001);
      check("stopped", bst(b), ex(BK_ACTIVE));
    end
    // clock suspend in a read burst
    cmd(1'b1, 1'b0, `SDC_CMD_READ, 2'h0, 12'h012, 2'h0);
    cmd(1'b0, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("suspend", 12'(pwr), ex(PS_SUSP));
    cmd(1'b0, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("suspend hold", bst(0), ex(BK_READ));
    cmd(1'b1, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("suspend exit", 12'(pwr), ex(PS_NORMAL));
    cmd(1'b1, 1'b0, `SDC_CMD_READ, 2'h1, 12'h434, 2'h0);
    check("rd ap on", {11'h000, auto_pre}, 12'h001);
    check("read ap", bst(1), ex(BK_READ_AP));
    cmd(1'b1, 1'b0, `SDC_CMD_PRE, 2'h2, 12'h000, 2'h0);
    check("pre one", bst(2), ex(BK_PRECHARGING));
    check("pre other", bst(3), ex(BK_ACTIVE));
    // the precharge time of bank 2 is kept before precharge all reaches it
    idle_cycles(3);
    check("pre one idle", bst(2), ex(BK_IDLE));
    cmd(1'b1, 1'b0, `SDC_CMD_PRE, 2'h2, 12'h400, 2'h0);
    check("pre all 0", bst(0), ex(BK_PRECHARGING));
    check("pre all 3", bst(3), ex(BK_PRECHARGING));
    check("pre idle bank", bst(2), ex(BK_IDLE));
    idle_cycles(3);
    check("all idle", st, 12'h000);
    // two-beat write with auto precharge closes the bank by itself
    cmd(1'b1, 1'b0, `SDC_CMD_MODE, 2'h0, 12'h001, 2'h0);
    cmd(1'b1, 1'b0, `SDC_CMD_ACT, 2'h0, 12'($random(seed)), 2'h0);
    idle_cycles(3);
    cmd(1'b1, 1'b0, `SDC_CMD_WRITE, 2'h0, 12'h400, 2'h0);
    check("wr ap", bst(0), ex(BK_WRITE_AP));
    idle_cycles(1);
    check("wr ap beat", bst(0), ex(BK_WRITE_AP));
    idle_cycles(1);
    check("wr ap end", bst(0), ex(BK_PRECHARGING));
    idle_cycles(3);
    check("wr ap idle", st, 12'h000);
    // read mask lags two edges; write mask never does
    for (int i = 0; i < 16; i++) begin
      r = 12'($random(seed)) & 12'h003;
      dq.push_back(r[1:0]);
      cmd(1'b1, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, r[1:0]);
      if (i > 0) begin
        check("rd mask", {10'h000, rd_mask}, {10'h000, dq[i-1]});
      end
    end
    cmd(1'b1, 1'b0, `SDC_CMD_REF, 2'h0, 12'h000, 2'h0);
    check("auto ref", {11'h000, refresh}, 12'h001);
    check("auto ref pwr", 12'(pwr), ex(PS_NORMAL));
    idle_cycles(8);
    // power-down; a command under low clock enable must be ignored
    cmd(1'b0, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("pdown", 12'(pwr), ex(PS_PDOWN));
    cmd(1'b0, 1'b0, `SDC_CMD_MODE, 2'h0, 12'hABC, 2'h0);
    check("pdown mode", mode_reg, 12'h001);
    check("pdown hold", 12'(pwr), ex(PS_PDOWN));
    cmd(1'b1, 1'b1, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("pdown exit", 12'(pwr), ex(PS_NORMAL));
    // self refresh and its recovery window
    r = ref_row;
    cmd(1'b0, 1'b0, `SDC_CMD_REF, 2'h0, 12'h000, 2'h0);
    check("self", 12'(pwr), ex(PS_SELF));
    check("self pulse", {11'h000, refresh}, 12'h001);
    check("self row", ref_row, r + 12'h001);
    cmd(1'b0, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    check("self hold", 12'(pwr), ex(PS_SELF));
    cmd(1'b1, 1'b0, `SDC_CMD_NO_OP, 2'h0, 12'h000, 2'h0);
    cnt = 0;
    while (pwr === PS_XSR && cnt < 20) begin
      cnt++;
      idle_cycles(1);
    end
    check("xsr cycles", 12'(cnt), 12'(`SDC_SELF_EXIT_CYC));
    check("xsr idle", 12'(pwr), ex(PS_NORMAL));
    summarize();
  end
endmodule
`default_nettype wire
